/* File: pin_side_model.sv */
// pin side model: external switches on the port a pins
// assumes: pull-downs reported per pin by the block
module pin_side_model (
    // from the block
    input  wire logic [3:0] port_a_out,
    input  wire logic [3:0] port_a_oe,
    input  wire logic [3:0] port_a_pd,
    // switch settings from the bench
    input  wire logic [3:0] ext_val,
    input  wire logic [3:0] ext_en,
    // pin levels to the block
    output logic      [3:0] port_a_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // resolve each pin: block drive, switch, pull-down, else inverted ext_val
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (port_a_oe[i]) port_a_in[i] = port_a_out[i];
            else if (ext_en[i]) port_a_in[i] = ext_val[i];
            else if (port_a_pd[i]) port_a_in[i] = 1'b0;
            else port_a_in[i] = ~ext_val[i];
        end
    end
endmodule // pin_side_model

/* File: port_a_defs.vh */
// port a defs: constants for the port a wake and pseudo-serial block
// assumes: included by port_a_wake_serial_io.v and port_a_filter.v
`ifndef PORT_A_DEFS_VH
`define PORT_A_DEFS_VH
// ----------------------------------------------------------------------
// register offsets (plain port, word per offset)
// ----------------------------------------------------------------------
`define PA_ADDR_W        4
`define PA_OFS_DIR       4'h0
`define PA_OFS_OUT       4'h1
`define PA_OFS_PIN       4'h2
`define PA_OFS_SERIAL    4'h3
`define PA_OFS_CTRL      4'h4
`define PA_OFS_STATUS    4'h5
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PA_SER_BIT0      0
`define PA_SER_BIT1      1
`define PA_SER_IMM       4
`define PA_CTRL_SEL_LO   0
`define PA_CTRL_SEL_HI   1
`define PA_CTRL_IRQ_EN   2
`define PA_CTRL_ARM      3
`define PA_CTRL_CLR_B    4
`define PA_CTRL_CLR_D    5
`define PA_ST_FLAG0      0
`define PA_ST_SEF        1
`define PA_ST_FILT       2
`define PA_ST_OR         3
// ----------------------------------------------------------------------
// reset values and clock-select codes
// ----------------------------------------------------------------------
`define PA_DIR_RST       4'h0
`define PA_OUT_RST       4'h0
`define PA_SEL_32MS      2'h0
`define PA_SEL_8MS       2'h1
`define PA_SEL_2MS       2'h2
// ----------------------------------------------------------------------
// timing: intervals in ms, converted at 200 MHz
// ----------------------------------------------------------------------
`define PA_CLK_HZ        200000000
`define PA_T32_MS        32
`define PA_T8_MS         8
`define PA_T2_MS         2
`define PA_TICKS(ms)     ((ms) * (`PA_CLK_HZ / 1000))
`endif

/* File: port_a_filter.v */
// port a filter: chattering filter on the ORed port a input
// assumes: single clk domain, input already synchronised
`include "port_a_defs.vh"
module port_a_filter #(
    parameter integer T32 = `PA_TICKS(`PA_T32_MS),
    parameter integer T8  = `PA_TICKS(`PA_T8_MS),
    parameter integer T2  = `PA_TICKS(`PA_T2_MS)
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // control
    input  wire [1:0] sel,
    input  wire       din,
    // filtered level and edge pulse
    output reg        level_q,
    output reg        edge_q
);
    reg  [31:0] cnt_q;
    reg         s1_q;
    reg  [31:0] lim;
    wire        tick;

    // chosen tick interval, longest by default
    always @* begin
        case (sel)
            `PA_SEL_8MS: lim = T8;
            `PA_SEL_2MS: lim = T2;
            default:     lim = T32;
        endcase
    end

    assign tick = (cnt_q + 32'h1 >= lim);

    // tick counter and two-tick stability
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= 32'h0;
            s1_q    <= 1'b0;
            level_q <= 1'b0;
            edge_q  <= 1'b0;
        end else begin
            edge_q <= 1'b0;
            cnt_q  <= tick ? 32'h0 : cnt_q + 32'h1;
            if (tick) begin
                s1_q <= din;
                if (s1_q == din && din != level_q) begin
                    level_q <= din;
                    edge_q  <= 1'b1;
                end
            end
        end
    end
endmodule // port_a_filter

/* File: port_a_wake_serial_io.v */
// port a wake serial io: four-pin port a with pseudo-serial out and
// start condition detection
// assumes: single 200 MHz clk, pins arrive asynchronously
`include "port_a_defs.vh"
module port_a_wake_serial_io #(
    parameter        FILTER_MODE = 1'b0,  // mask option: 1 = filter
    parameter [3:0]  PULL_DOWN   = 4'hf,  // mask option per pin
    parameter [3:0]  PIN_SHARED  = 4'h0,  // mask option: pin elsewhere
    parameter integer T32 = `PA_TICKS(`PA_T32_MS),
    parameter integer T8  = `PA_TICKS(`PA_T8_MS),
    parameter integer T2  = `PA_TICKS(`PA_T2_MS)
) (
    // clock and reset
    input  wire                 clk,
    input  wire                 rst,
    // register port
    input  wire [`PA_ADDR_W-1:0] addr,
    input  wire [7:0]           wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [7:0]           rdata,
    // port a pins, four of them
    input  wire [3:0]           port_a_in,
    output reg  [3:0]           port_a_out,
    output reg  [3:0]           port_a_oe,
    output reg  [3:0]           port_a_pd,
    // start flag results
    output reg                  start_cond_flag_zero,
    output reg                  halt_release_req_zero,
    output reg                  irq_req,
    output reg                  clr_start_flags_bd
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg  [3:0] dir_q;
    reg  [3:0] out_q;
    reg  [3:0] s1_q, s2_q, s3_q;
    reg  [3:0] stable_q;
    reg  [1:0] sel_q;
    reg        irq_en_q;
    reg        sef_q;
    reg        or_prev_q;
    reg        flt_prev_q;
    reg        ser_q;
    reg        ser_phase_q;
    reg  [2:0] ser_d_q;
    wire [3:0] live;
    wire       or_in;
    wire       flt_level;
    wire       flt_edge;
    wire       set_ev;
    wire       arm;
    wire [3:0] ser_pins;

    function [3:0] mux_pins;
        input [3:0] sel;
        input [3:0] a;
        input [3:0] b;
        begin
            mux_pins = (sel & a) | (~sel & b);
        end
    endfunction

    // pins given to other functions stay idle inputs
    assign live = dir_q & ~PIN_SHARED;

    // ------------------------------------------------------------------
    // input synchroniser: three stages, agree on last two
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q     <= 4'h0;
            s2_q     <= 4'h0;
            s3_q     <= 4'h0;
            stable_q <= 4'h0;
        end else begin
            s1_q <= port_a_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
        end
    end

    // OR of input-mode pins only
    assign or_in = |(stable_q & ~dir_q & ~PIN_SHARED);

    port_a_filter #(
        .T32 (T32),
        .T8  (T8),
        .T2  (T2)
    ) u_filter (
        .clk     (clk),
        .rst     (rst),
        .sel     (sel_q),
        .din     (or_in),
        .level_q (flt_level),
        .edge_q  (flt_edge)
    );

    assign arm = wr && addr == `PA_OFS_CTRL && wdata[`PA_CTRL_ARM];

    // level or filter source per mask option
    assign set_ev = sef_q && (FILTER_MODE ? flt_edge
                                          : (or_in && !or_prev_q));

    // ------------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_q    <= `PA_DIR_RST;            // all inputs
            out_q    <= `PA_OUT_RST;
            sel_q    <= `PA_SEL_32MS;           // longest default
            irq_en_q <= 1'b0;
            sef_q    <= 1'b0;
        end else if (wr) begin
            case (addr)
                `PA_OFS_DIR: dir_q <= wdata[3:0];
                `PA_OFS_OUT: out_q <= wdata[3:0];
                `PA_OFS_CTRL: begin
                    sel_q    <= wdata[`PA_CTRL_SEL_HI:`PA_CTRL_SEL_LO];
                    irq_en_q <= wdata[`PA_CTRL_IRQ_EN];
                    if (wdata[`PA_CTRL_ARM])
                        sef_q <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // start flag: sticky, ignores changes until re-armed; arm wins over a new set event while the flag is set
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            start_cond_flag_zero  <= 1'b0;
            halt_release_req_zero <= 1'b0;
            irq_req               <= 1'b0;
            clr_start_flags_bd    <= 1'b0;
            or_prev_q             <= 1'b0;
            flt_prev_q            <= 1'b0;
        end else begin
            or_prev_q  <= or_in;
            flt_prev_q <= flt_level;
            // arming clears flags zero, one and three together
            clr_start_flags_bd <= arm;
            if (set_ev && !start_cond_flag_zero)
                start_cond_flag_zero <= 1'b1;
            else if (arm)
                start_cond_flag_zero <= 1'b0;
            // halt release follows the flag; interrupt follows it only while irq_en_q is set
            halt_release_req_zero <= (set_ev && !start_cond_flag_zero) |
                                     (halt_release_req_zero && !arm);
            irq_req <= irq_en_q &&
                       ((set_ev && !start_cond_flag_zero) ||
                        (start_cond_flag_zero && !arm));
        end
    end

    // ------------------------------------------------------------------
    // pseudo-serial out: one write drives data and enable with a one-cycle strobe
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ser_q       <= 1'b0;
            ser_phase_q <= 1'b0;
            ser_d_q     <= 3'h0;
        end else begin
            ser_phase_q <= 1'b0;
            if (wr && addr == `PA_OFS_SERIAL) begin
                ser_q   <= 1'b1;
                ser_d_q <= {wdata[`PA_SER_IMM],
                            wdata[`PA_SER_BIT1],
                            wdata[`PA_SER_BIT0]};
                ser_phase_q <= 1'b1;
            end else if (wr && addr == `PA_OFS_OUT) begin
                ser_q <= 1'b0;  // plain port write takes the pins back
            end
        end
    end

    // strobe on pin four only in the first cycle after the serial write
    assign ser_pins = {ser_phase_q, ser_d_q};

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            port_a_out <= 4'h0;
            port_a_oe  <= 4'h0;
            port_a_pd  <= 4'h0;
        end else begin
            // outputs show register or serial pattern
            port_a_out <= live & (ser_q ? ser_pins : out_q);
            port_a_oe  <= live;
            port_a_pd  <= PULL_DOWN & ~live & ~PIN_SHARED;
        end
    end

    // ------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `PA_OFS_DIR: rdata <= {4'h0, dir_q};
                `PA_OFS_OUT: rdata <= {4'h0, out_q};
                // pins in input mode, register in output mode
                `PA_OFS_PIN: rdata <= {4'h0,
                                       mux_pins(dir_q, out_q, stable_q)};
                `PA_OFS_CTRL: rdata <= {5'h0, irq_en_q, sel_q};
                `PA_OFS_STATUS: rdata <= {4'h0, or_in, flt_prev_q,
                                          sef_q, start_cond_flag_zero};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // port_a_wake_serial_io

/* File: port_a_wake_serial_io_monitor.sv */
// port a monitor: concurrent checks on the port a block ports
// assumes: bound to port_a_wake_serial_io, single clk, async rst
`include "port_a_defs.vh"
module port_a_wake_serial_io_monitor (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // register port
    input wire logic [`PA_ADDR_W-1:0]  addr,
    input wire logic [7:0]             wdata,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [7:0]             rdata,
    // pins and flags
    input wire logic [3:0]             port_a_in,
    input wire logic [3:0]             port_a_out,
    input wire logic [3:0]             port_a_oe,
    input wire logic [3:0]             port_a_pd,
    input wire logic                   start_cond_flag_zero,
    input wire logic                   halt_release_req_zero,
    input wire logic                   irq_req,
    input wire logic                   clr_start_flags_bd
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // read data is zero outside the cycle after a read
    property p_rdata_idle;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read answer");
    // pull-down only on pins that are not driven
    property p_pd_input;
        (port_a_pd & port_a_oe) == 4'h0;
    endproperty
    a_pd_input: assert property (p_pd_input)
        else $error("pull-down active on driving pin");
    // direction write reaches the enables two cycles later
    property p_dir_write;
        wr && addr == `PA_OFS_DIR |-> ##2 port_a_oe == $past(wdata[3:0], 2);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not seen on enables");
    // flag holds until an arm write
    property p_flag_sticky;
        start_cond_flag_zero && !(wr && addr == `PA_OFS_CTRL && wdata[3])
            |=> start_cond_flag_zero;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("start flag dropped without arm");
    // halt release request accompanies the flag
    property p_halt_req;
        start_cond_flag_zero |-> halt_release_req_zero;
    endproperty
    a_halt_req: assert property (p_halt_req)
        else $error("halt release missing with start flag");
    // interrupt only with the flag set
    property p_irq_flag;
        irq_req |-> start_cond_flag_zero;
    endproperty
    a_irq_flag: assert property (p_irq_flag)
        else $error("interrupt without start flag");
    // arming pulses the clear to ports b and d once
    property p_clr_bd;
        wr && addr == `PA_OFS_CTRL && wdata[3]
            |-> ##[1:2] clr_start_flags_bd ##1 !clr_start_flags_bd;
    endproperty
    a_clr_bd: assert property (p_clr_bd)
        else $error("clear pulse to ports b and d missing");
    // serial write: data, enable and strobe together for one cycle, then strobe low
    property p_serial;
        wr && addr == `PA_OFS_SERIAL |-> ##2
            port_a_out == {1'b1, $past(wdata[4], 2), $past(wdata[1:0], 2)}
            ##1 !port_a_out[3];
    endproperty
    a_serial: assert property (p_serial)
        else $error("pseudo serial pattern wrong");
endmodule // port_a_wake_serial_io_monitor
bind port_a_wake_serial_io port_a_wake_serial_io_monitor
    port_a_wake_serial_io_monitor_i (.*);

/* File: test_port_a_wake_serial_io.sv */
// test port a: directed scenarios on the port a block in level mode
// assumes: pin_side_model on the pins, monitor bound to the block
`include "port_a_defs.vh"
module test_port_a_wake_serial_io;
    timeunit 1ns;
    timeprecision 100ps;
    logic                  clk, rst, wr, rd, flag, halt, irq, clr_bd;
    logic [`PA_ADDR_W-1:0] addr;
    logic [7:0]            wdata, rdata, d;
    logic [3:0]            pin_in, pin_out, pin_oe, pin_pd, ext_val, ext_en;
    int                    bad_count, checks_done;
    // ------------------------------------------------------------
    // block, pins and clock
    // ------------------------------------------------------------
    port_a_wake_serial_io #(.FILTER_MODE(1'b0), .T32(20), .T8(10), .T2(5))
    port_a_wake_serial_io_i (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .port_a_in(pin_in), .port_a_out(pin_out),
        .port_a_oe(pin_oe), .port_a_pd(pin_pd),
        .start_cond_flag_zero(flag), .halt_release_req_zero(halt),
        .irq_req(irq), .clr_start_flags_bd(clr_bd));
    pin_side_model pin_side_model_i (
        .port_a_out(pin_out), .port_a_oe(pin_oe), .port_a_pd(pin_pd),
        .ext_val(ext_val), .ext_en(ext_en), .port_a_in(pin_in));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_flag;
        int n;
        for (n = 0; n < 30 && flag !== 1'b1; n++) @(posedge clk);
        if (n == 30) begin bad_count++; give_verdict(); end
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_dir_out;
        chk({4'h0, pin_oe}, 8'h00);
        chk({4'h0, pin_pd}, 8'h0f);
        wr_reg(`PA_OFS_OUT, 8'h0a);
        wr_reg(`PA_OFS_DIR, 8'h0f);
        repeat (3) @(posedge clk);
        #1 chk({pin_oe, pin_out}, 8'hfa);
        rd_reg(`PA_OFS_PIN, d);
        chk(d, 8'h0a);
        wr_reg(`PA_OFS_DIR, 8'h03);
        ext_en <= 4'hf;
        ext_val <= 4'hc;
        repeat (6) @(posedge clk);
        rd_reg(`PA_OFS_PIN, d);
        chk(d, 8'h0e);
        chk({4'h0, pin_pd}, 8'h0c);
        wr_reg(`PA_OFS_DIR, 8'h00);
        ext_val <= 4'h0;
    endtask
    task automatic t_level;
        wr_reg(`PA_OFS_CTRL, 8'h0c);
        repeat (6) @(posedge clk);
        #1 chk({7'h0, flag}, 8'h00);
        ext_val <= 4'h2;
        wait_flag();
        chk({6'h0, halt, irq}, 8'h03);
        rd_reg(`PA_OFS_STATUS, d);
        chk(d & 8'h0b, 8'h0b);
        ext_val <= 4'h6;
        repeat (6) @(posedge clk);
        ext_val <= 4'h0;
        repeat (6) @(posedge clk);
        #1 chk({7'h0, flag}, 8'h01);
        wr_reg(`PA_OFS_CTRL, 8'h08);
        #1 chk({7'h0, clr_bd}, 8'h01);
        repeat (3) @(posedge clk);
        #1 chk({4'h0, halt, clr_bd, flag, irq}, 8'h00);
        ext_val <= 4'h8;
        wait_flag();
        chk({6'h0, halt, irq}, 8'h02);
        rd_reg(4'hf, d);
        chk(d, 8'h00);
    endtask
    task automatic t_serial;
        wr_reg(`PA_OFS_DIR, 8'h0f);
        wr_reg(`PA_OFS_SERIAL, 8'h11);
        @(posedge clk) #1 chk({4'h0, pin_out}, 8'h0d);
        @(posedge clk) #1 chk({4'h0, pin_out}, 8'h05);
        wr_reg(`PA_OFS_SERIAL, 8'h02);
        @(posedge clk) #1 chk({4'h0, pin_out}, 8'h0a);
        @(posedge clk) #1 chk({4'h0, pin_out}, 8'h02);
        wr_reg(`PA_OFS_OUT, 8'h09);
        @(posedge clk) #1 chk({4'h0, pin_out}, 8'h09);
    endtask
    // shortest filter tick: level follows, short glitch is dropped
    task automatic t_filter;
        wr_reg(`PA_OFS_CTRL, 8'h02);
        rd_reg(`PA_OFS_CTRL, d);
        chk(d, 8'h02);
        repeat (30) @(posedge clk);
        rd_reg(`PA_OFS_STATUS, d);
        chk(d & 8'h0c, 8'h0c);
        ext_val <= 4'h0;
        repeat (2) @(posedge clk);
        ext_val <= 4'h8;
        repeat (30) @(posedge clk);
        rd_reg(`PA_OFS_STATUS, d);
        chk(d & 8'h0c, 8'h0c);
        ext_val <= 4'h0;
        repeat (30) @(posedge clk);
        rd_reg(`PA_OFS_STATUS, d);
        chk(d & 8'h0c, 8'h00);
    endtask
    // reset in mid-run returns every pin to input
    task automatic t_reset;
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1 chk({pin_oe, 3'h0, flag}, 8'h00);
        chk({4'h0, pin_pd}, 8'h0f);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, addr, wdata, wr, rd, ext_val, ext_en} = {1'b1, 22'h0};
        bad_count = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1;
        t_dir_out();
        t_level();
        t_filter();
        t_serial();
        t_reset();
        give_verdict();
    end
endmodule // test_port_a_wake_serial_io
